// file: design/ubgfc_pkg.sv
// Shared constants for the bridge-side baud, pin and flow-control block.
// Assumes a single 50 MHz system clock and a plain register port.
package ubgfc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] REG_LINE = 4'h0;
    localparam logic [3:0] REG_BAUD_REQ = 4'h1;
    localparam logic [3:0] REG_BAUD_STAT = 4'h2;
    localparam logic [3:0] REG_PIN = 4'h3;
    localparam logic [3:0] REG_CFG = 4'h4;
    localparam logic [3:0] REG_LOCK = 4'h5;
    localparam logic [3:0] REG_STR_IDX = 4'h6;
    localparam logic [3:0] REG_STR_DATA = 4'h7;
    localparam logic [3:0] REG_STR_LEN = 4'h8;
    localparam logic [31:0] CLK_HZ = 32'd50000000;
    localparam logic [31:0] REF_HZ = 32'd48000000;
    localparam logic [31:0] BAUD_MIN = 32'd300;
    localparam logic [31:0] BAUD_MAX = 32'd2000000;
    localparam logic [31:0] PRESCALE_EDGE = 32'd365;
    localparam logic [2:0] PRE_SLOW = 3'h4;
    localparam logic [2:0] PRE_FAST = 3'h1;
    localparam logic [9:0] RTS_WATERMARK = 10'h17f;
    localparam logic [5:0] SER_MAX = 6'h3f;
    localparam logic [6:0] PROD_MAX = 7'h7e;
    localparam int STR_DEPTH = 189;
    localparam logic [1:0] PIN_INPUT = 2'h0;
    localparam logic [1:0] PIN_OPEN_DRAIN = 2'h1;
    localparam logic [1:0] PIN_PUSH_PULL = 2'h2;
    localparam logic [1:0] STOP_ONE = 2'h0;
    localparam logic [1:0] STOP_ONE_HALF = 2'h1;
    localparam logic [1:0] DATA_FIVE = 2'h0;
    localparam int CFG_ALT_TX = 8;
    localparam int CFG_ALT_RX = 9;
    localparam int CFG_ALT_485 = 10;
    localparam int CFG_485_LOW = 11;
    localparam int CFG_FLUSH_TX = 12;
    localparam int CFG_FLUSH_RX = 13;
    localparam int CFG_HW_FLOW = 16;
    localparam logic [16:0] CFG_DEFAULT = 17'h03000;
    localparam int STAT_PRE_BIT = 16;
    localparam int STAT_BUSY_BIT = 17;
    localparam logic [31:0] TOGGLE_US = 32'd50000;
    localparam logic [31:0] CLK_MHZ = CLK_HZ / 32'd1000000;
    localparam logic [31:0] TOGGLE_HALF_CYC = TOGGLE_US * CLK_MHZ / 32'd2;
    typedef enum logic [2:0] {
        UBGFC_DIV_IDLE = 3'b001,
        UBGFC_DIV_RUN = 3'b010,
        UBGFC_DIV_DONE = 3'b100
    } ubgfc_div_e;
endpackage

// file: design/ubgfc_top.sv
// Baud generator, four configurable pins (three with alternate functions),
// RTS/CTS flow control and write-once configuration store.
// Assumes UART framing logic outside reports activity and fill level.
`timescale 1ns/1ps
`default_nettype none
module ubgfc_top
    import ubgfc_pkg::*;
#(
    parameter logic [31:0] TOGGLE_HALF = TOGGLE_HALF_CYC
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Register port.
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // UART status from the framing logic.
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic break_active,
    input wire logic [9:0] rx_fill,
    input wire logic port_open,
    // Flow control and line setup.
    input wire logic cts_n,
    output logic rts_n,
    output logic tx_allow,
    output logic baud_tick,
    output logic [1:0] data_bits_sel,
    output logic [1:0] stop_sel,
    output logic flush_tx,
    output logic flush_rx,
    // General-purpose pins.
    input wire logic [3:0] gpio_i,
    output logic [3:0] gpio_o,
    output logic [3:0] gpio_oe,
    output logic [3:0] gpio_pu
);
    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    logic wr_line, wr_baud, wr_pin, wr_cfg, wr_lock, wr_idx, wr_str, wr_len;
    assign wr_line = reg_wr && reg_addr == REG_LINE;
    assign wr_baud = reg_wr && reg_addr == REG_BAUD_REQ;
    assign wr_pin = reg_wr && reg_addr == REG_PIN;
    assign wr_cfg = reg_wr && reg_addr == REG_CFG;
    assign wr_lock = reg_wr && reg_addr == REG_LOCK;
    assign wr_idx = reg_wr && reg_addr == REG_STR_IDX;
    assign wr_str = reg_wr && reg_addr == REG_STR_DATA;
    assign wr_len = reg_wr && reg_addr == REG_STR_LEN;

    // Line format; an illegal half stop bit falls back to one stop bit.
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            data_bits_sel <= DATA_FIVE;
            stop_sel <= STOP_ONE;
        end else if (wr_line) begin
            data_bits_sel <= reg_wdata[1:0];
            if (reg_wdata[3:2] == STOP_ONE_HALF && reg_wdata[1:0] != DATA_FIVE) begin
                stop_sel <= STOP_ONE;
            end else begin
                stop_sel <= reg_wdata[3:2];
            end
        end
    end

    // Write-once configuration store. Writes before the lock take effect
    // at once; the lock blocks every later change except to the string index.
    logic locked_ff;
    logic [16:0] cfg_ff;
    logic [7:0] str_idx_ff;
    logic [5:0] ser_len_ff;
    logic [6:0] prod_len_ff;
    logic [7:0] str_mem [0:STR_DEPTH-1];
    logic [7:0] str_q_ff;
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            locked_ff <= 1'b0;
            cfg_ff <= CFG_DEFAULT;
            str_idx_ff <= 8'h00;
            ser_len_ff <= 6'h08;
            prod_len_ff <= 7'h00;
        end else begin
            if (wr_lock && reg_wdata[0]) begin
                locked_ff <= 1'b1;
            end
            if (wr_cfg && !locked_ff) begin
                cfg_ff <= reg_wdata[16:0];
            end
            if (wr_idx) begin
                str_idx_ff <= reg_wdata[7:0];
            end else if (wr_str && str_idx_ff < 8'(STR_DEPTH)) begin
                str_idx_ff <= str_idx_ff + 8'h01;
            end
            if (wr_len && !locked_ff) begin
                ser_len_ff <= reg_wdata[5:0] > SER_MAX ? SER_MAX : reg_wdata[5:0];
                prod_len_ff <= reg_wdata[14:8] > PROD_MAX ? PROD_MAX : reg_wdata[14:8];
            end
        end
    end

    // String bytes have no reset; memory is left as a plain array.
    always_ff @(posedge mclk) begin
        if (wr_str && !locked_ff && str_idx_ff < 8'(STR_DEPTH)) begin
            str_mem[str_idx_ff] <= reg_wdata[7:0];
        end
        str_q_ff <= str_idx_ff < 8'(STR_DEPTH) ? str_mem[str_idx_ff] : 8'h00;
    end

    // Rounded divider: (REF + pre*rate) / (2*pre*rate), one bit per cycle.
    ubgfc_div_e div_st_ff;
    logic [31:0] rem_ff, quo_ff, den_ff;
    logic [4:0] step_ff;
    logic [2:0] pre_calc_ff, pre_ff;
    logic [16:0] clk_div_ff;
    logic [19:0] period_ff;
    logic [31:0] req_clamp, pre_rate;
    logic [2:0] pre_sel;
    logic [32:0] rem_sh;
    always_comb begin
        if (reg_wdata < BAUD_MIN) begin
            req_clamp = BAUD_MIN;
        end else if (reg_wdata > BAUD_MAX) begin
            req_clamp = BAUD_MAX;
        end else begin
            req_clamp = reg_wdata;
        end
        pre_sel = req_clamp <= PRESCALE_EDGE ? PRE_SLOW : PRE_FAST;
        pre_rate = req_clamp * {29'h0, pre_sel};
        rem_sh = {rem_ff, quo_ff[31]};
    end

    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            div_st_ff <= UBGFC_DIV_IDLE;
            rem_ff <= 32'h0;
            quo_ff <= 32'h0;
            den_ff <= 32'h1;
            step_ff <= 5'h0;
            pre_calc_ff <= PRE_FAST;
            pre_ff <= PRE_FAST;
            clk_div_ff <= 17'h00019;
            period_ff <= 20'h00032;
        end else begin
            unique case (div_st_ff)
                UBGFC_DIV_IDLE: begin
                    if (wr_baud) begin
                        den_ff <= {pre_rate[30:0], 1'b0};
                        quo_ff <= REF_HZ + pre_rate;
                        rem_ff <= 32'h0;
                        step_ff <= 5'h1f;
                        pre_calc_ff <= pre_sel;
                        div_st_ff <= UBGFC_DIV_RUN;
                    end
                end
                UBGFC_DIV_RUN: begin
                    if (rem_sh >= {1'b0, den_ff}) begin
                        rem_ff <= 32'(rem_sh - {1'b0, den_ff});
                        quo_ff <= {quo_ff[30:0], 1'b1};
                    end else begin
                        rem_ff <= rem_sh[31:0];
                        quo_ff <= {quo_ff[30:0], 1'b0};
                    end
                    step_ff <= step_ff - 5'h1;
                    if (step_ff == 5'h0) begin
                        div_st_ff <= UBGFC_DIV_DONE;
                    end
                end
                UBGFC_DIV_DONE: begin
                    clk_div_ff <= quo_ff[16:0] == 17'h0 ? 17'h00001 : quo_ff[16:0];
                    pre_ff <= pre_calc_ff;
                    period_ff <= 20'({17'h0, pre_calc_ff} * {3'h0, quo_ff[16:0]} * 20'h2);
                    div_st_ff <= UBGFC_DIV_IDLE;
                end
            endcase
        end
    end

    // A 48 MHz reference is emulated by a rate accumulator on the system
    // clock, so edges jitter by one system period but the mean rate is exact.
    logic [31:0] ref_acc_ff;
    logic ref_tick_ff;
    logic [19:0] bit_cnt_ff;
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ref_acc_ff <= 32'h0;
            ref_tick_ff <= 1'b0;
            bit_cnt_ff <= 20'h0;
            baud_tick <= 1'b0;
        end else begin
            if (ref_acc_ff + REF_HZ >= CLK_HZ) begin
                ref_acc_ff <= ref_acc_ff + REF_HZ - CLK_HZ;
                ref_tick_ff <= 1'b1;
            end else begin
                ref_acc_ff <= ref_acc_ff + REF_HZ;
                ref_tick_ff <= 1'b0;
            end
            baud_tick <= 1'b0;
            if (div_st_ff == UBGFC_DIV_DONE) begin
                bit_cnt_ff <= 20'h0;
            end else if (ref_tick_ff) begin
                if (bit_cnt_ff + 20'h1 >= period_ff) begin
                    bit_cnt_ff <= 20'h0;
                    baud_tick <= 1'b1;
                end else begin
                    bit_cnt_ff <= bit_cnt_ff + 20'h1;
                end
            end
        end
    end

    // Activity indicators idle high and toggle while the transfer runs.
    logic [31:0] tog_cnt_ff;
    logic tx_led_ff, rx_led_ff;
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            tog_cnt_ff <= 32'h0;
            tx_led_ff <= 1'b1;
            rx_led_ff <= 1'b1;
        end else begin
            if (tog_cnt_ff + 32'h1 >= TOGGLE_HALF) begin
                tog_cnt_ff <= 32'h0;
            end else begin
                tog_cnt_ff <= tog_cnt_ff + 32'h1;
            end
            if (!tx_active) begin
                tx_led_ff <= 1'b1;
            end else if (tog_cnt_ff == 32'h0) begin
                tx_led_ff <= !tx_led_ff;
            end
            if (!rx_active) begin
                rx_led_ff <= 1'b1;
            end else if (tog_cnt_ff == 32'h0) begin
                rx_led_ff <= !rx_led_ff;
            end
        end
    end

    // Pin drivers; plain pin values are software-timed only.
    logic [3:0] pin_out_ff;
    logic transceiver_driver_enable;
    logic [3:0] pin_val, nxt_o, nxt_oe, nxt_pu;
    assign transceiver_driver_enable = (tx_active || break_active) ^ cfg_ff[CFG_485_LOW];
    always_comb begin
        pin_val = pin_out_ff;
        if (cfg_ff[CFG_ALT_TX]) begin
            pin_val[0] = tx_led_ff;
        end
        if (cfg_ff[CFG_ALT_RX]) begin
            pin_val[1] = rx_led_ff;
        end
        if (cfg_ff[CFG_ALT_485]) begin
            pin_val[2] = transceiver_driver_enable;
        end
        for (int i = 0; i < 4; i++) begin
            unique case (cfg_ff[2*i +: 2])
                PIN_OPEN_DRAIN: begin
                    nxt_o[i] = 1'b0;
                    nxt_oe[i] = !pin_val[i];
                    nxt_pu[i] = 1'b1;
                end
                PIN_PUSH_PULL: begin
                    nxt_o[i] = pin_val[i];
                    nxt_oe[i] = 1'b1;
                    nxt_pu[i] = 1'b0;
                end
                default: begin
                    nxt_o[i] = 1'b0;
                    nxt_oe[i] = 1'b0;
                    nxt_pu[i] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pin_out_ff <= 4'h0;
            gpio_o <= 4'h0;
            gpio_oe <= 4'h0;
            gpio_pu <= 4'h0;
        end else begin
            if (wr_pin) begin
                pin_out_ff <= reg_wdata[3:0];
            end
            gpio_o <= nxt_o;
            gpio_oe <= nxt_oe;
            gpio_pu <= nxt_pu;
        end
    end

    // Flow control and open-time flushes. Stopping at once on CTS leaves
    // the two-byte allowance unused, which keeps the far buffer safest.
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rts_n <= 1'b0;
            tx_allow <= 1'b1;
            flush_tx <= 1'b0;
            flush_rx <= 1'b0;
        end else begin
            rts_n <= cfg_ff[CFG_HW_FLOW] && rx_fill >= RTS_WATERMARK;
            tx_allow <= !(cfg_ff[CFG_HW_FLOW] && cts_n);
            flush_tx <= port_open && cfg_ff[CFG_FLUSH_TX];
            flush_rx <= port_open && cfg_ff[CFG_FLUSH_RX];
        end
    end

    // Read port; unmapped offsets read as zero.
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_LINE: reg_rdata <= {28'h0, stop_sel, data_bits_sel};
                REG_BAUD_STAT: reg_rdata <= {13'h0, div_st_ff != UBGFC_DIV_IDLE,
                    pre_ff == PRE_SLOW, clk_div_ff};
                REG_PIN: reg_rdata <= {28'h0, gpio_i};
                REG_CFG: reg_rdata <= {15'h0, cfg_ff};
                REG_LOCK: reg_rdata <= {31'h0, locked_ff};
                REG_STR_IDX: reg_rdata <= {24'h0, str_idx_ff};
                REG_STR_DATA: reg_rdata <= {24'h0, str_q_ff};
                REG_STR_LEN: reg_rdata <= {17'h0, prod_len_ff, 2'h0, ser_len_ff};
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end
endmodule
`default_nettype wire

// file: tb/ubgfc_checker.sv
// Port assertions for the baud, pin and flow-control block.
// Assumes binding to ubgfc_top, one clock and the raw reset.
`timescale 1ns/1ps
`default_nettype none
module ubgfc_checker
    import ubgfc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Register port.
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    // Status, line and flow.
    input wire logic port_open,
    input wire logic [9:0] rx_fill,
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic tx_allow,
    input wire logic baud_tick,
    input wire logic [1:0] data_bits_sel,
    input wire logic [1:0] stop_sel,
    input wire logic flush_tx,
    input wire logic flush_rx,
    // Pins.
    input wire logic [3:0] gpio_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic seen_ff;
    logic flow_ff;
    logic lock_ff;
    // The flow bit mirrors only accepted writes, since the lock refuses later ones.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            seen_ff <= 1'b0;
            flow_ff <= 1'b0;
            lock_ff <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == REG_LOCK && reg_wdata[0]) begin
                lock_ff <= 1'b1;
            end
            if (reg_wr && reg_addr == REG_CFG && !lock_ff) begin
                seen_ff <= 1'b1;
                flow_ff <= reg_wdata[CFG_HW_FLOW];
            end
        end
    end
    sequence s_quiet;
        !baud_tick [*8];
    endsequence
    chk_rts_high_fill: assert property (
        rts_n |-> $past(flow_ff) && $past(rx_fill) >= RTS_WATERMARK)
        else $error("rts raised below the watermark");
    chk_rts_low_fill: assert property (
        $fell(rts_n) |-> $past(rx_fill) < RTS_WATERMARK || !$past(flow_ff))
        else $error("rts released at or above the watermark");
    chk_rts_flow_on: assert property (
        $past(flow_ff) && $past(rx_fill) >= RTS_WATERMARK |-> rts_n)
        else $error("rts not raised with flow control on");
    chk_stop_allow: assert property (!tx_allow |-> $past(cts_n))
        else $error("transmit held while cts low");
    chk_tick_gap: assert property (baud_tick |=> s_quiet)
        else $error("baud ticks too close");
    chk_flush_cause: assert property ((flush_tx || flush_rx) |-> $past(port_open))
        else $error("flush without port open");
    chk_half_stop: assert property (stop_sel == STOP_ONE_HALF |-> data_bits_sel == DATA_FIVE)
        else $error("one and a half stop bits with wrong length");
    chk_pin_default: assert property (!seen_ff |-> gpio_oe == 4'h0)
        else $error("pin driven before configuration");
    chk_cts_stop: assert property ($past(flow_ff) && $past(cts_n) |-> !tx_allow)
        else $error("transmit not held while cts high");
    chk_allow_free: assert property (!$past(flow_ff) |-> tx_allow)
        else $error("transmit held without flow control");
endmodule
bind ubgfc_top ubgfc_checker i_chk (
    .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .port_open, .rx_fill, .cts_n,
    .rts_n, .tx_allow, .baud_tick, .data_bits_sel, .stop_sel, .flush_tx, .flush_rx,
    .gpio_oe
);
`default_nettype wire

// file: tb/ubgfc_far_uart.sv
// Far-side UART peer with its flow handshake, and the pin pads.
// Assumes the bench tells it when its receive buffer nears full.
`timescale 1ns/1ps
`default_nettype none
module ubgfc_far_uart (
    // Flow control.
    input wire logic full,
    input wire logic rts_n,
    output logic cts_n,
    output logic sending,
    // Pins.
    input wire logic [3:0] gpio_o,
    input wire logic [3:0] gpio_oe,
    input wire logic [3:0] gpio_pu,
    input wire logic [3:0] ext_lvl,
    output logic [3:0] pad
);
    assign cts_n = full;
    assign sending = !rts_n;
    // A released pin shows its pull-up or the outside level, never the last drive.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pad[i] = gpio_oe[i] ? gpio_o[i] : (gpio_pu[i] | ext_lvl[i]);
        end
    end
endmodule
`default_nettype wire

// file: tb/ubgfc_bench.sv
// Self-checking bench for the baud, pin and flow-control block.
// Assumes the peer model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ubgfc_bench import ubgfc_pkg::*;;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic tx_a = 1'b0;
    logic rx_a = 1'b0;
    logic brk = 1'b0;
    logic [9:0] fill = 10'h0;
    logic popen = 1'b0;
    logic full = 1'b0;
    logic [3:0] ext = 4'h8;
    logic [31:0] rdata;
    logic cts_n, rts_n, tx_allow, tick, ftx, frx, sending;
    logic [1:0] dbits, stop;
    logic [3:0] go, goe, gpu, pad;
    int miscompares = 0;
    int comparisons = 0;
    always #10 mclk = ~mclk;
    ubgfc_top #(.TOGGLE_HALF(32'd8)) i_dut (
        .mclk(mclk), .nrst(nrst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s),
        .reg_rd(rd_s), .reg_rdata(rdata), .tx_active(tx_a), .rx_active(rx_a),
        .break_active(brk), .rx_fill(fill), .port_open(popen), .cts_n(cts_n),
        .rts_n(rts_n), .tx_allow(tx_allow), .baud_tick(tick), .data_bits_sel(dbits),
        .stop_sel(stop), .flush_tx(ftx), .flush_rx(frx), .gpio_i(pad), .gpio_o(go),
        .gpio_oe(goe), .gpio_pu(gpu)
    );
    ubgfc_far_uart i_far (
        .full(full), .rts_n(rts_n), .cts_n(cts_n), .sending(sending), .gpio_o(go),
        .gpio_oe(goe), .gpio_pu(gpu), .ext_lvl(ext), .pad(pad)
    );
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        @(posedge mclk);
        chk(rdata, e);
    endtask
    task automatic gap(output logic [31:0] n);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (tick !== 1'b1 && n < 32'd200);
    endtask
    task automatic t_defaults();
        rc(REG_CFG, 32'(CFG_DEFAULT));
        rc(REG_BAUD_STAT, 32'd25);
        rc(4'hf, 32'h0);
        chk({28'h0, goe}, 32'h0);
        popen <= 1'b1;
        @(posedge mclk);
        popen <= 1'b0;
        @(posedge mclk);
        chk({30'h0, ftx, frx}, 32'h3);
    endtask
    task automatic t_baud();
        logic [31:0] r, p, e, n;
        logic [31:0] req [6] = '{32'd100, 32'd300, 32'd365, 32'd366, 32'd9600, 32'd3000000};
        foreach (req[i]) begin
            r = req[i] < BAUD_MIN ? BAUD_MIN : (req[i] > BAUD_MAX ? BAUD_MAX : req[i]);
            p = r <= PRESCALE_EDGE ? 32'd4 : 32'd1;
            e = (REF_HZ + p * r) / (32'd2 * p * r);
            wr(REG_BAUD_REQ, req[i]);
            cyc(40);
            rc(REG_BAUD_STAT, {14'h0, p == 32'd4, e[16:0]});
        end
        gap(n);
        gap(n);
        chk(n, 32'd25);
        wr(REG_BAUD_REQ, 32'd9600);
        wr(REG_BAUD_REQ, 32'd300);
        cyc(40);
        rc(REG_BAUD_STAT, 32'd2500);
    endtask
    task automatic t_pins();
        wr(REG_CFG, 32'h29);
        wr(REG_PIN, 32'hf);
        cyc(1);
        chk({20'h0, go & goe, goe, 3'h0, gpu[0]}, 32'h661);
        wr(REG_PIN, 32'h0);
        cyc(1);
        chk({24'h0, goe, go & goe}, 32'h70);
        rc(REG_PIN, 32'h8);
    endtask
    task automatic t_alt();
        logic [31:0] n;
        logic [1:0] b;
        wr(REG_CFG, 32'h72a);
        cyc(1);
        chk({29'h0, go[2:0]}, 32'h3);
        tx_a <= 1'b1;
        rx_a <= 1'b1;
        cyc(2);
        chk({31'h0, go[2]}, 32'h1);
        n = 0;
        repeat (32) begin
            b = go[1:0];
            @(posedge mclk);
            n = n + 32'(go[0] !== b[0]) + 32'(go[1] !== b[1]);
        end
        chk(n, 32'd8);
        tx_a <= 1'b0;
        rx_a <= 1'b0;
        brk <= 1'b1;
        cyc(3);
        chk({29'h0, go[2:0]}, 32'h7);
        wr(REG_CFG, 32'hf2a);
        cyc(1);
        chk({31'h0, go[2]}, 32'h0);
        brk <= 1'b0;
        cyc(2);
        chk({31'h0, go[2]}, 32'h1);
    endtask
    task automatic t_flow();
        wr(REG_CFG, 32'h10000);
        fill <= 10'd382;
        cyc(3);
        chk({31'h0, rts_n}, 32'h0);
        fill <= 10'd383;
        full <= 1'b1;
        cyc(2);
        chk({29'h0, sending, rts_n, tx_allow}, 32'h2);
        wr(REG_CFG, 32'h0);
        cyc(1);
        chk({29'h0, sending, rts_n, tx_allow}, 32'h5);
        full <= 1'b0;
        fill <= 10'd0;
    endtask
    task automatic t_line();
        wr(REG_LINE, 32'h4);
        chk({28'h0, stop, dbits}, 32'h4);
        wr(REG_LINE, 32'h7);
        chk({28'h0, stop, dbits}, 32'h3);
    endtask
    task automatic t_store();
        wr(REG_STR_LEN, 32'h7f3f);
        rc(REG_STR_LEN, 32'h7e3f);
        wr(REG_STR_IDX, 32'd62);
        wr(REG_STR_DATA, 32'h5a);
        rc(REG_STR_IDX, 32'd63);
        wr(REG_STR_IDX, 32'd62);
        rc(REG_STR_DATA, 32'h5a);
        wr(REG_CFG, 32'h10000);
        wr(REG_LOCK, 32'h1);
        wr(REG_CFG, 32'h3000);
        rc(REG_CFG, 32'h10000);
        wr(REG_STR_DATA, 32'ha5);
        wr(REG_STR_IDX, 32'd62);
        rc(REG_STR_DATA, 32'h5a);
    endtask
    task automatic end_sim();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        cyc(12);
        nrst <= 1'b1;
        cyc(3);
        t_defaults();
        t_baud();
        t_pins();
        t_alt();
        t_flow();
        t_line();
        t_store();
        end_sim();
    end
    initial begin
        cyc(20000);
        miscompares++;
        end_sim();
    end
endmodule
`default_nettype wire
